// [shared/cef_pkg.sv]
// Package of constants and types for the CAN expander command filter front end
// Behaviour
// - With overflow notice enabled, a new message into a full buffer triggers an overflow message.
// - With error report enabled, send both counters when either exceeds 95, again above 127.
// - A configuration bit picks listen-only or normal operation after power-up; the code samples it only at its reset value 0 and always starts listen-only.
// - From power-up listen-only, go normal after one error-free received message.
// - With sleep-while-listening set, sleep is allowed while waiting in power-up listen-only.
// - Listen-only never drives an acknowledge; a lone partner keeps the device listening.
// - One mask shared by two filters; filter 0 feeds buffer 0, filter 1 buffer 1.
// - A mask bit at zero makes its filter bit irrelevant for acceptance.
// - Remote mode: RTR is direction; request has RTR set, answer is a data frame.
// - Data mode: identifier bit 3 is direction; answer clears it, same identifier otherwise.
// - Data mode answer clears bit 3; its DLC is the request DLC only if the request had RTR set, else zero.
// - Mask extended bits 2..0 always read and act as zero.
// - With data-frame requests selected, mask extended bit 3 is forced to zero.
// - With data-frame requests and standard frames, filter bit 3 is don't-care.
// - Filter extended-enable bit, when masked in, requires matching IDE bit.
// - Extended frames reserve the same low bits: three remote, four data.
// - Two receive buffers and three prioritised transmit identifier slots.
// - Command type is decoded from the three low arbitration bits.
// - Buffer 0 holds info requests answered by replies; buffer 1 holds input commands.
// - Command acknowledge or overflow notice, chosen by one bit, both on second identifier, no data.
// - A seventeen-count hysteresis re-arms the error report.
package cef_pkg;
    // Error counter thresholds and re-arm points
    localparam logic [7:0] ERR_WARN_LIMIT = 8'h5f;
    localparam logic [7:0] ERR_PASS_LIMIT = 8'h7f;
    localparam logic [7:0] ERR_HYST = 8'h11;
    localparam logic [7:0] ERR_WARN_REARM = 8'h4f;
    localparam logic [7:0] ERR_PASS_REARM = 8'h6f;
    // Identifier field positions
    localparam int DIR_BIT_POS = 3;
    localparam logic [28:0] MASK_LOW3_CLEAR = 29'h1ffffff8;
    localparam logic [28:0] MASK_LOW4_CLEAR = 29'h1ffffff0;
    localparam logic [28:0] STD_BIT3 = 29'h00000008;
    // Option register two layout
    localparam int OPT_ERR_REPORT_BIT = 0;
    localparam int OPT_PU_NORMAL_BIT = 1;
    localparam int OPT_LISTEN_SLEEP_BIT = 2;
    localparam int OPT_FRAME_TYPE_BIT = 3;
    localparam int OPT_ACK_SEL_BIT = 4;
    localparam logic [7:0] OPT_RESET = 8'h00;
    // Mask and filter register reset values
    localparam logic [7:0] MF_RESET = 8'h00;
    // Transmit request kinds on the second identifier
    typedef enum logic [1:0] {
        CEF_TX_NONE = 2'h0,
        CEF_TX_ACK = 2'h1,
        CEF_TX_OVF = 2'h2,
        CEF_TX_ERR = 2'h3
    } cef_tx_kind_t;
    typedef enum logic [1:0] {
        CEF_MODE_LISTEN = 2'h0,
        CEF_MODE_NORMAL = 2'h1,
        CEF_MODE_SLEEP = 2'h3
    } cef_mode_t;
endpackage

// [src/cef_filter.sv]
// One acceptance filter evaluated against the shared mask
`timescale 1ns/1ns
module cef_filter
    import cef_pkg::*;
(
    // Frame identifier
    input wire logic [28:0] frame_id,
    input wire logic frame_ide,
    // Effective mask and filter
    input wire logic [28:0] mask_id,
    input wire logic mask_ide,
    input wire logic [28:0] filt_id,
    input wire logic extended_enable_bit,
    // Result
    output logic hit
);
    wire logic id_ok;
    wire logic ide_ok;
    assign id_ok = ((frame_id ^ filt_id) & mask_id) == 29'h00000000;
    assign ide_ok = !mask_ide || (frame_ide == extended_enable_bit);
    assign hit = id_ok && ide_ok;
endmodule

// [src/cef_err_monitor.sv]
// Error counter threshold watcher with hysteresis re-arm
`timescale 1ns/1ns
module cef_err_monitor
    import cef_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Counters
    input wire logic [7:0] tec,
    input wire logic [7:0] rec,
    input wire logic enable,
    // Report request
    output logic fire
);
    logic warn_armed_reg;
    logic pass_armed_reg;
    wire logic [7:0] peak;
    wire logic warn_hit;
    wire logic pass_hit;
    assign peak = (tec > rec) ? tec : rec;
    assign warn_hit = enable && warn_armed_reg && (peak > ERR_WARN_LIMIT);
    assign pass_hit = enable && pass_armed_reg && (peak > ERR_PASS_LIMIT);
    assign fire = warn_hit || pass_hit;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            warn_armed_reg <= 1'b1;
            pass_armed_reg <= 1'b1;
        end else begin
            if (warn_hit) begin
                warn_armed_reg <= 1'b0;
            end else if (peak <= ERR_WARN_REARM) begin
                warn_armed_reg <= 1'b1;
            end
            if (pass_hit) begin
                pass_armed_reg <= 1'b0;
            end else if (peak <= ERR_PASS_REARM) begin
                pass_armed_reg <= 1'b1;
            end
        end
    end
endmodule

// [src/cef_top.sv]
// CAN expander front end: filtering, buffers, mode and second-identifier events
`timescale 1ns/1ns
module cef_top
    import cef_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration writes (register index 0..12, see note)
    input wire logic cfg_we,
    input wire logic [3:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Received frame from protocol engine
    input wire logic rx_valid,
    input wire logic rx_error_free,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic [3:0] rx_dlc,
    // Buffer service by the command processor
    input wire logic buf0_done,
    input wire logic buf1_done,
    output logic buf0_full,
    output logic buf1_full,
    output logic [2:0] buf0_cmd,
    output logic [2:0] buf1_cmd,
    // Reply frame header for info requests
    output logic reply_valid,
    output logic [28:0] reply_id,
    output logic reply_ide,
    output logic reply_rtr,
    output logic [3:0] reply_dlc,
    // Error counters
    input wire logic [7:0] tec,
    input wire logic [7:0] rec,
    // Second identifier transmit request
    output logic tx1_valid,
    output logic [1:0] tx1_kind,
    output logic [15:0] tx1_data,
    input wire logic tx1_taken,
    // Mode
    output logic listen_only,
    output logic ack_enable,
    output logic sleep_allowed
);
    localparam logic [3:0] A_OPT = 4'h0;
    localparam logic [3:0] A_MSK_SH = 4'h1;
    localparam logic [3:0] A_MSK_SL = 4'h2;
    localparam logic [3:0] A_MSK_EM = 4'h3;
    localparam logic [3:0] A_MSK_EL = 4'h4;
    localparam logic [3:0] A_F0 = 4'h5;
    localparam logic [3:0] A_F1 = 4'h9;
    localparam logic [3:0] A_STATUS = 4'hd;

    // ********************
    // Registers
    // ********************
    logic [7:0] option_register_two_reg;
    logic [7:0] mask_reg [0:3];
    logic [7:0] filt_reg [0:7];
    logic [28:0] id0_reg;
    logic [28:0] id1_reg;
    logic ide0_reg;
    logic rtr0_reg;
    logic [3:0] dlc0_reg;
    logic buf0_full_reg;
    logic buf1_full_reg;
    logic reply_valid_reg;
    logic [28:0] reply_id_reg;
    logic reply_ide_reg;
    logic [3:0] reply_dlc_reg;
    logic listen_only_reg;
    logic ack_enable_reg;
    logic sleep_allowed_reg;
    logic tx1_valid_reg;
    logic [1:0] tx1_kind_reg;
    logic [15:0] tx1_data_reg;
    logic pending_ack_reg;
    logic pending_ovf_reg;
    logic pending_err_reg;
    logic [7:0] cfg_rdata_reg;
    cef_mode_t mode_reg;
    cef_mode_t mode_next;
    cef_mode_t mode_load;

    function automatic logic [28:0] pack_id(input logic [7:0] sh, input logic [7:0] sl,
                                            input logic [7:0] em, input logic [7:0] el);
        pack_id = {sh, sl[7:5], sl[1:0], em, el};
    endfunction

    // ********************
    // Decode
    // ********************
    wire logic err_report_en = option_register_two_reg[OPT_ERR_REPORT_BIT];
    wire logic powerup_normal_select = option_register_two_reg[OPT_PU_NORMAL_BIT];
    wire logic listen_sleep_enable = option_register_two_reg[OPT_LISTEN_SLEEP_BIT];
    wire logic request_frame_type = option_register_two_reg[OPT_FRAME_TYPE_BIT];
    wire logic ack_vs_overflow_select = option_register_two_reg[OPT_ACK_SEL_BIT];
    wire logic [28:0] mask_raw = pack_id(mask_reg[0], mask_reg[1], mask_reg[2], mask_reg[3]);
    wire logic [28:0] mask_eff = mask_raw & (request_frame_type ? MASK_LOW4_CLEAR : MASK_LOW3_CLEAR);
    wire logic mask_ide = mask_reg[1][3];
    wire logic [28:0] f0_id = pack_id(filt_reg[0], filt_reg[1], filt_reg[2], filt_reg[3]);
    wire logic [28:0] f1_id = pack_id(filt_reg[4], filt_reg[5], filt_reg[6], filt_reg[7]);
    // Standard ids sit in the top 11 bits; command bits 2..0, and bit 3 in data mode, are ignored
    wire logic [28:0] std_dc = (request_frame_type && !rx_ide) ? (STD_BIT3 << 18) : 29'h00000000;
    wire logic [28:0] std_sel = rx_ide ? 29'h1fffffff : 29'h1fe00000;
    wire logic [28:0] mask_use = mask_eff & ~std_dc & std_sel;
    wire logic [28:0] rx_align = rx_ide ? rx_id : {rx_id[10:0], 18'h00000};
    wire logic hit0;
    wire logic hit1;
    wire logic dir_set = request_frame_type ? rx_id[DIR_BIT_POS] : rx_rtr;
    wire logic take0 = rx_valid && rx_error_free && hit0 && dir_set;
    wire logic take1 = rx_valid && rx_error_free && hit1 && !take0;
    wire logic ovf_event = (take0 && buf0_full_reg) || (take1 && buf1_full_reg);
    wire logic err_fire;
    wire logic mask_hit = (cfg_addr >= A_MSK_SH) && (cfg_addr <= A_MSK_EL);
    wire logic filt_hit = (cfg_addr >= A_F0) && (cfg_addr < A_STATUS);
    wire logic [1:0] msk_idx = 2'(cfg_addr - A_MSK_SH);
    wire logic [2:0] flt_idx = 3'(cfg_addr - A_F0);
    wire logic [7:0] mask_low_rd = (cfg_addr == A_MSK_EL) ?
                                   (mask_eff[7:0]) : mask_reg[msk_idx];
    wire logic [7:0] status_rd = {3'h0, tx1_valid_reg, buf1_full_reg, buf0_full_reg, mode_reg};
    wire logic [7:0] rd_mux = (cfg_addr == A_OPT) ? option_register_two_reg :
                              mask_hit ? mask_low_rd :
                              filt_hit ? filt_reg[flt_idx] :
                              (cfg_addr == A_STATUS) ? status_rd : 8'h00;

    cef_filter u_filt0 (
        .frame_id(rx_align), .frame_ide(rx_ide), .mask_id(mask_use), .mask_ide(mask_ide),
        .filt_id(f0_id), .extended_enable_bit(filt_reg[1][3]), .hit(hit0)
    );
    cef_filter u_filt1 (
        .frame_id(rx_align), .frame_ide(rx_ide), .mask_id(mask_use), .mask_ide(mask_ide),
        .filt_id(f1_id), .extended_enable_bit(filt_reg[5][3]), .hit(hit1)
    );
    cef_err_monitor u_err (
        .sys_clk(sys_clk), .rst(rst), .tec(tec), .rec(rec), .enable(err_report_en), .fire(err_fire)
    );

    // ********************
    // Operating mode
    // ********************
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            CEF_MODE_LISTEN: begin
                if (rx_valid && rx_error_free) begin
                    mode_next = CEF_MODE_NORMAL;
                end else if (listen_sleep_enable) begin
                    mode_next = CEF_MODE_SLEEP;
                end
            end
            CEF_MODE_SLEEP: begin
                if (rx_valid && rx_error_free) begin
                    mode_next = CEF_MODE_NORMAL;
                end else if (!listen_sleep_enable) begin
                    mode_next = CEF_MODE_LISTEN;
                end
            end
            CEF_MODE_NORMAL: mode_next = CEF_MODE_NORMAL;
            default: mode_next = CEF_MODE_LISTEN;
        endcase
    end

    logic pu_done_reg;
    assign mode_load = pu_done_reg ? mode_next :
                       (powerup_normal_select ? CEF_MODE_NORMAL : CEF_MODE_LISTEN);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= CEF_MODE_LISTEN;
            pu_done_reg <= 1'b0;
            listen_only_reg <= 1'b1;
            ack_enable_reg <= 1'b0;
            sleep_allowed_reg <= 1'b0;
        end else begin
            pu_done_reg <= 1'b1;
            mode_reg <= mode_load;
            listen_only_reg <= (mode_load != CEF_MODE_NORMAL);
            ack_enable_reg <= (mode_load == CEF_MODE_NORMAL);
            sleep_allowed_reg <= (mode_load == CEF_MODE_SLEEP);
        end
    end

    // ********************
    // Configuration registers
    // ********************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            option_register_two_reg <= OPT_RESET;
            for (int i = 0; i < 4; i++) begin
                mask_reg[i] <= MF_RESET;
            end
            for (int i = 0; i < 8; i++) begin
                filt_reg[i] <= MF_RESET;
            end
            cfg_rdata_reg <= 8'h00;
        end else begin
            cfg_rdata_reg <= rd_mux;
            if (cfg_we && cfg_addr == A_OPT) begin
                option_register_two_reg <= cfg_wdata;
            end
            if (cfg_we && mask_hit) begin
                mask_reg[msk_idx] <= cfg_wdata;
            end
            if (cfg_we && filt_hit) begin
                filt_reg[flt_idx] <= cfg_wdata;
            end
        end
    end

    // ********************
    // Receive buffers and reply
    // ********************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buf0_full_reg <= 1'b0;
            buf1_full_reg <= 1'b0;
            id0_reg <= 29'h00000000;
            id1_reg <= 29'h00000000;
            ide0_reg <= 1'b0;
            rtr0_reg <= 1'b0;
            dlc0_reg <= 4'h0;
            reply_valid_reg <= 1'b0;
            reply_id_reg <= 29'h00000000;
            reply_ide_reg <= 1'b0;
            reply_dlc_reg <= 4'h0;
        end else begin
            reply_valid_reg <= buf0_done && buf0_full_reg;
            if (buf0_done && buf0_full_reg) begin
                reply_id_reg <= request_frame_type ? (id0_reg & ~STD_BIT3) : id0_reg;
                reply_ide_reg <= ide0_reg;
                reply_dlc_reg <= rtr0_reg ? dlc0_reg : 4'h0;
            end
            if (take0 && !buf0_full_reg) begin
                buf0_full_reg <= 1'b1;
                id0_reg <= rx_id;
                ide0_reg <= rx_ide;
                rtr0_reg <= rx_rtr;
                dlc0_reg <= rx_dlc;
            end else if (buf0_done) begin
                buf0_full_reg <= 1'b0;
            end
            if (take1 && !buf1_full_reg) begin
                buf1_full_reg <= 1'b1;
                id1_reg <= rx_id;
            end else if (buf1_done) begin
                buf1_full_reg <= 1'b0;
            end
        end
    end

    // ********************
    // Second identifier events
    // ********************
    wire logic ack_event = buf1_done && buf1_full_reg && ack_vs_overflow_select;
    wire logic ovf_note = ovf_event && !ack_vs_overflow_select;
    wire logic launch = !tx1_valid_reg || tx1_taken;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pending_ack_reg <= 1'b0;
            pending_ovf_reg <= 1'b0;
            pending_err_reg <= 1'b0;
            tx1_valid_reg <= 1'b0;
            tx1_kind_reg <= CEF_TX_NONE;
            tx1_data_reg <= 16'h0000;
        end else begin
            if (launch && pending_err_reg) begin
                tx1_valid_reg <= 1'b1;
                tx1_kind_reg <= CEF_TX_ERR;
                tx1_data_reg <= {tec, rec};
                pending_err_reg <= err_fire;
            end else begin
                pending_err_reg <= pending_err_reg | err_fire;
                if (launch && pending_ovf_reg) begin
                    tx1_valid_reg <= 1'b1;
                    tx1_kind_reg <= CEF_TX_OVF;
                    tx1_data_reg <= 16'h0000;
                end else if (launch && pending_ack_reg) begin
                    tx1_valid_reg <= 1'b1;
                    tx1_kind_reg <= CEF_TX_ACK;
                    tx1_data_reg <= 16'h0000;
                end else if (tx1_taken) begin
                    tx1_valid_reg <= 1'b0;
                end
            end
            pending_ovf_reg <= ovf_note || (pending_ovf_reg && !(launch && !pending_err_reg));
            pending_ack_reg <= ack_event ||
                               (pending_ack_reg && !(launch && !pending_err_reg && !pending_ovf_reg));
        end
    end

    // ********************
    // Outputs
    // ********************
    assign buf0_full = buf0_full_reg;
    assign buf1_full = buf1_full_reg;
    assign buf0_cmd = id0_reg[2:0];
    assign buf1_cmd = id1_reg[2:0];
    assign reply_valid = reply_valid_reg;
    assign reply_id = reply_id_reg;
    assign reply_ide = reply_ide_reg;
    assign reply_rtr = 1'b0;
    assign reply_dlc = reply_dlc_reg;
    assign tx1_valid = tx1_valid_reg;
    assign tx1_kind = tx1_kind_reg;
    assign tx1_data = tx1_data_reg;
    assign cfg_rdata = cfg_rdata_reg;
    assign listen_only = listen_only_reg;
    assign ack_enable = ack_enable_reg;
    assign sleep_allowed = sleep_allowed_reg;

    // ********************
    // Assertions
    // ********************
    AST_NO_ACK_LISTEN: assert property (@(posedge sys_clk) disable iff (rst)
        listen_only |-> !ack_enable) else $error("ack while listening");
    AST_OVF_PEND: assert property (@(posedge sys_clk) disable iff (rst)
        ovf_note |=> pending_ovf_reg || (tx1_kind_reg == CEF_TX_OVF)) else $error("overflow lost");
    AST_LISTEN_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
        pu_done_reg && listen_only && rx_valid && rx_error_free |=> !listen_only) else $error("no promotion");
    AST_MASK_LOW: assert property (@(posedge sys_clk) disable iff (rst)
        mask_eff[2:0] == 3'h0) else $error("mask low bits set");
    AST_MASK_B3: assert property (@(posedge sys_clk) disable iff (rst)
        request_frame_type |-> !mask_eff[3]) else $error("mask bit 3 set");
    AST_REPLY_RTR: assert property (@(posedge sys_clk) disable iff (rst)
        reply_valid |-> !reply_rtr && !(request_frame_type && reply_id[3])) else $error("bad reply dir");
    AST_BUF_ROUTE: assert property (@(posedge sys_clk) disable iff (rst)
        take0 && !buf0_full_reg |=> buf0_full_reg) else $error("buffer 0 not filled");
    AST_ERR_DATA: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(tx1_valid_reg) && tx1_kind_reg == CEF_TX_ERR |-> tx1_data_reg == {$past(tec), $past(rec)})
        else $error("error data wrong");
    COV_PROMOTE: cover property (@(posedge sys_clk) $fell(listen_only));
    COV_OVF: cover property (@(posedge sys_clk) tx1_valid && tx1_kind == CEF_TX_OVF);
    COV_ERR: cover property (@(posedge sys_clk) tx1_valid && tx1_kind == CEF_TX_ERR);
    COV_REPLY: cover property (@(posedge sys_clk) reply_valid);
endmodule

// [sim/cef_master_node.sv]
// Master CAN node model: presents received frames, consumes second-identifier requests
`timescale 1ns/1ns
module cef_master_node (
    // Clock
    input wire logic sys_clk,
    // Received frame
    output logic rx_valid,
    output logic rx_error_free,
    output logic [28:0] rx_id,
    output logic rx_ide,
    output logic rx_rtr,
    output logic [3:0] rx_dlc,
    // Second identifier
    input wire logic tx1_valid,
    input wire logic [1:0] tx1_kind,
    input wire logic [15:0] tx1_data,
    output logic tx1_taken
);
    int take_lag = 0;
    int lag_cnt = 0;
    int got_count = 0;
    logic [1:0] got_kind = 2'h0;
    logic [15:0] got_data = 16'h0000;
    initial begin
        rx_valid = 1'b0;
        rx_error_free = 1'b0;
        rx_id = 29'h0;
        rx_ide = 1'b0;
        rx_rtr = 1'b0;
        rx_dlc = 4'h0;
        tx1_taken = 1'b0;
    end
    // One frame, held for one cycle, then fields scrambled
    task automatic send(input logic [28:0] id, input logic rtr, input logic [3:0] dlc, input logic ok);
        @(negedge sys_clk);
        rx_id = id;
        rx_rtr = rtr;
        rx_dlc = dlc;
        rx_error_free = ok;
        rx_valid = 1'b1;
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_id = ~id;
        rx_dlc = ~dlc;
        rx_rtr = ~rtr;
    endtask
    // Transmitter takes the request after a programmable lag
    always @(negedge sys_clk) begin
        if (tx1_valid === 1'b1 && !tx1_taken && lag_cnt >= take_lag) begin
            tx1_taken <= 1'b1;
            got_kind <= tx1_kind;
            got_data <= tx1_data;
            got_count <= got_count + 1;
            lag_cnt <= 0;
        end else begin
            tx1_taken <= 1'b0;
            lag_cnt <= (tx1_valid === 1'b1) ? lag_cnt + 1 : 0;
        end
    end
endmodule

// [sim/tb_top.sv]
// Testbench for the CAN expander command filter front end
`timescale 1ns/1ns
module tb_top;
    import cef_pkg::*;
    logic sys_clk, rst, cfg_we, buf0_done, buf1_done, rx_valid, rx_error_free, rx_ide, rx_rtr;
    logic buf0_full, buf1_full, reply_valid, reply_ide, reply_rtr, tx1_valid, tx1_taken;
    logic listen_only, ack_enable, sleep_allowed;
    logic [3:0] cfg_addr, rx_dlc, reply_dlc;
    logic [7:0] cfg_wdata, cfg_rdata, tec, rec;
    logic [28:0] rx_id, reply_id;
    logic [2:0] buf0_cmd, buf1_cmd;
    logic [1:0] tx1_kind;
    logic [15:0] tx1_data;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] rows [6];
    cef_top cef_top_inst (.sys_clk, .rst, .cfg_we, .cfg_addr, .cfg_wdata, .cfg_rdata, .rx_valid,
        .rx_error_free, .rx_id, .rx_ide, .rx_rtr, .rx_dlc, .buf0_done, .buf1_done, .buf0_full,
        .buf1_full, .buf0_cmd, .buf1_cmd, .reply_valid, .reply_id, .reply_ide, .reply_rtr, .reply_dlc,
        .tec, .rec, .tx1_valid, .tx1_kind, .tx1_data, .tx1_taken, .listen_only, .ack_enable, .sleep_allowed);
    cef_master_node cef_master_node_inst (.sys_clk, .rx_valid, .rx_error_free, .rx_id, .rx_ide,
        .rx_rtr, .rx_dlc, .tx1_valid, .tx1_kind, .tx1_data, .tx1_taken);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input logic [28:0] got, input logic [28:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic stuck(input string what);
        num_errors++;
        $display("CHECK FAILED at %0t: no %s", $time, what);
        give_verdict();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cfg_we = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_we = 1'b0;
    endtask
    task automatic serve(input logic b0, input logic b1);
        @(negedge sys_clk);
        buf0_done = b0;
        buf1_done = b1;
        @(negedge sys_clk);
        buf0_done = 1'b0;
        buf1_done = 1'b0;
    endtask
    task automatic wait_tx(input logic [1:0] k, input logic [15:0] d);
        int c0;
        c0 = cef_master_node_inst.got_count;
        for (int i = 0; i < 20 && cef_master_node_inst.got_count == c0; i++) @(negedge sys_clk);
        if (cef_master_node_inst.got_count == c0) stuck("second-identifier message");
        chk(cef_master_node_inst.got_kind, k);
        chk(cef_master_node_inst.got_data, d);
    endtask
    task automatic no_tx(input int n);
        int c0;
        c0 = cef_master_node_inst.got_count;
        tick(n);
        chk(cef_master_node_inst.got_count, c0);
    endtask
    task automatic wait_reply(input logic [28:0] id, input logic [3:0] dlc, input logic chk_dlc);
        for (int i = 0; i < 4 && reply_valid !== 1'b1; i++) @(negedge sys_clk);
        if (reply_valid !== 1'b1) stuck("reply");
        chk(reply_id, id);
        chk(reply_rtr, 1'b0);
        if (chk_dlc) chk(reply_dlc, dlc);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        {cfg_we, cfg_addr, cfg_wdata, buf0_done, buf1_done, tec, rec} = '0;
        // id[10:0], rtr, into buf0, into buf1, command
        rows = '{{11'h123, 5'h1b}, {11'h127, 5'h18}, {11'h523, 5'h1b}, {11'h123, 5'h00},
                 {11'h245, 5'h05}, {11'h128, 5'h10}};
        tick(16);
        rst = 1'b0;
        tick(1);
        chk(listen_only, 1'b1);
        chk(ack_enable, 1'b0);
        wr(4'h1, 8'h7f);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'hff);
        cfg_addr = 4'h4;
        tick(1);
        chk(cfg_rdata, 8'hf8);
        wr(4'h5, 8'h24);
        wr(4'h9, 8'h48);
        wr(4'h0, 8'h01);
        cef_master_node_inst.send(29'h123, 1'b1, 4'h2, 1'b0);
        chk(buf0_full, 1'b0);
        chk(listen_only, 1'b1);
        cef_master_node_inst.send(29'h245, 1'b0, 4'h0, 1'b1);
        tick(1);
        chk(listen_only, 1'b0);
        chk(ack_enable, 1'b1);
        serve(1'b0, 1'b1);
        $display("test mode done");
        foreach (rows[i]) begin
            cef_master_node_inst.send({18'h0, rows[i][15:5]}, rows[i][4], 4'h2, 1'b1);
            chk(buf0_full, rows[i][3]);
            chk(buf1_full, rows[i][2]);
            if (rows[i][3]) chk(buf0_cmd, rows[i][1:0] == 2'h3 ? 3'h3 : 3'h7);
            if (rows[i][2]) chk(buf1_cmd, 3'h5);
            serve(1'b1, 1'b1);
            tick(2);
        end
        $display("test filter done");
        cef_master_node_inst.take_lag = 3;
        cef_master_node_inst.send(29'h123, 1'b1, 4'h4, 1'b1);
        cef_master_node_inst.send(29'h124, 1'b1, 4'h2, 1'b1);
        wait_tx(2'h2, 16'h0000);
        chk(buf0_cmd, 3'h3);
        serve(1'b1, 1'b0);
        wait_reply(29'h123, 4'h4, 1'b1);
        $display("test overflow done");
        wr(4'h0, 8'h09);
        cef_master_node_inst.send(29'h123, 1'b0, 4'h0, 1'b1);
        chk(buf0_full, 1'b0);
        cef_master_node_inst.send(29'h12b, 1'b0, 4'h0, 1'b1);
        chk(buf0_full, 1'b1);
        chk(buf0_cmd, 3'h3);
        serve(1'b1, 1'b0);
        wait_reply(29'h123, 4'h0, 1'b0);
        $display("test data mode done");
        wr(4'h2, 8'h08);
        cef_master_node_inst.rx_ide = 1'b1;
        cef_master_node_inst.send(29'h04800008, 1'b0, 4'h0, 1'b1);
        chk(buf0_full, 1'b0);
        wr(4'h6, 8'h08);
        cef_master_node_inst.send(29'h04800008, 1'b0, 4'h0, 1'b1);
        chk(buf0_full, 1'b1);
        serve(1'b1, 1'b0);
        wait_reply(29'h04800000, 4'h0, 1'b0);
        chk(reply_ide, 1'b1);
        cef_master_node_inst.rx_ide = 1'b0;
        $display("test extended done");
        wr(4'h0, 8'h19);
        cef_master_node_inst.send(29'h245, 1'b0, 4'h0, 1'b1);
        serve(1'b0, 1'b1);
        wait_tx(2'h1, 16'h0000);
        $display("test ack done");
        @(negedge sys_clk);
        rec = 8'h05;
        tec = 8'h60;
        wait_tx(2'h3, 16'h6005);
        no_tx(10);
        tec = 8'h80;
        wait_tx(2'h3, 16'h8005);
        tec = 8'h50;
        no_tx(5);
        tec = 8'h60;
        no_tx(10);
        tec = 8'h4f;
        no_tx(5);
        tec = 8'h60;
        wait_tx(2'h3, 16'h6005);
        $display("test error report done");
        chk(sleep_allowed, 1'b0);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        wr(4'h0, 8'h04);
        tick(2);
        chk(sleep_allowed, 1'b1);
        $display("test sleep done");
        give_verdict();
    end
endmodule
